// ==== include/cbse_pkg.sv ====
// Constants and types shared by the branch, I/O bit and shift executor.
`default_nettype none

package cbse_pkg;

  // ----------------------------------------------------------------
  // Widths
  // ----------------------------------------------------------------
  localparam int unsigned DATA_W    = 8;
  localparam int unsigned PC_W      = 16;
  localparam int unsigned INSTR_W   = 16;
  localparam int unsigned ADR_W     = 9;
  localparam int unsigned MEM_AW    = 5;
  localparam int unsigned MEM_DEPTH = 32;
  localparam int unsigned CYC_W     = 2;

  // ----------------------------------------------------------------
  // Bus map
  // ----------------------------------------------------------------
  localparam logic [8:0] ADR_INSTR   = 9'h000;
  localparam logic [8:0] ADR_PC      = 9'h004;
  localparam logic [8:0] ADR_SREG    = 9'h008;
  localparam logic [8:0] ADR_STAT    = 9'h00c;
  localparam logic [1:0] REGION_CTL  = 2'h0;
  localparam logic [1:0] REGION_RF   = 2'h1;
  localparam logic [1:0] REGION_IO   = 2'h2;
  localparam int unsigned REGION_LSB = 7;
  localparam int unsigned INDEX_LSB  = 2;

  // ----------------------------------------------------------------
  // Status flag positions
  // ----------------------------------------------------------------
  localparam logic [2:0] FLG_C = 3'h0;
  localparam logic [2:0] FLG_Z = 3'h1;
  localparam logic [2:0] FLG_N = 3'h2;
  localparam logic [2:0] FLG_V = 3'h3;
  localparam logic [2:0] FLG_S = 3'h4;
  localparam logic [2:0] FLG_H = 3'h5;
  localparam logic [2:0] FLG_T = 3'h6;
  localparam logic [2:0] FLG_I = 3'h7;

  // ----------------------------------------------------------------
  // Status register fields
  // ----------------------------------------------------------------
  localparam int unsigned STAT_BUSY    = 0;
  localparam int unsigned STAT_BAD     = 1;
  localparam int unsigned STAT_CYC_LSB = 4;

  // ----------------------------------------------------------------
  // Reset values and cycle counts
  // ----------------------------------------------------------------
  localparam logic [15:0] PC_RST    = 16'h0000;
  localparam logic [15:0] INSTR_RST = 16'h0000;
  localparam logic [7:0]  SREG_RST  = 8'h00;
  localparam logic [1:0]  CYC_RST   = 2'h0;
  localparam logic [1:0]  CYC_ONE   = 2'h1;
  localparam logic [1:0]  CYC_TWO   = 2'h2;

  // ----------------------------------------------------------------
  // Instruction encodings and fields
  // ----------------------------------------------------------------
  localparam logic [15:0] MASK_BRANCH = 16'hf800;
  localparam logic [15:0] OPC_BRANCH  = 16'hf000;
  localparam logic [15:0] MASK_IO     = 16'hff00;
  localparam logic [15:0] OPC_IO_SET  = 16'h9a00;
  localparam logic [15:0] OPC_IO_CLR  = 16'h9800;
  localparam logic [15:0] MASK_TWO    = 16'hfc00;
  localparam logic [15:0] OPC_SHL     = 16'h0c00;
  localparam logic [15:0] OPC_ROL     = 16'h1c00;
  localparam logic [15:0] MASK_ONE    = 16'hfe0f;
  localparam logic [15:0] OPC_SHR     = 16'h9406;
  localparam logic [15:0] OPC_ROR     = 16'h9407;
  localparam int unsigned BR_POL_BIT  = 10;
  localparam int unsigned BR_OFS_MSB  = 9;
  localparam int unsigned BR_OFS_LSB  = 3;
  localparam int unsigned RD_MSB      = 8;
  localparam int unsigned RD_LSB      = 4;
  localparam int unsigned IOA_MSB     = 7;
  localparam int unsigned IOA_LSB     = 3;
  localparam int unsigned BIT_MSB     = 2;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef enum logic [1:0] {
    ST_IDLE   = 2'b00,
    ST_EXEC   = 2'b01,
    ST_SECOND = 2'b10
  } cbse_state_type;

  typedef enum logic [2:0] {
    OP_BAD                  = 3'b000,
    OP_BRANCH               = 3'b001,
    OP_IO_BIT_SET           = 3'b010,
    OP_IO_BIT_CLEAR         = 3'b011,
    OP_SHIFT_LEFT_LOGICAL   = 3'b100,
    OP_SHIFT_RIGHT_LOGICAL  = 3'b101,
    OP_ROTATE_LEFT_CARRY    = 3'b110,
    OP_ROTATE_RIGHT_CARRY   = 3'b111
  } cbse_op_type;

endpackage : cbse_pkg

`default_nettype wire

// ==== include/cbse_mem_if.sv ====
// Port bundle between the executor and one of its small memories.
`default_nettype none

interface cbse_mem_if;
  logic [4:0] addr;
  logic       we;
  logic [7:0] wdata;
  logic [7:0] rdata;

  modport host (output addr, output we, output wdata, input rdata);
  modport mem  (input addr, input we, input wdata, output rdata);
endinterface : cbse_mem_if

`default_nettype wire

// ==== hw/cbse_mem.sv ====
// Small byte memory with registered read data.
`default_nettype none

module cbse_mem (
  input  wire logic clk_in,
  cbse_mem_if.mem   port
);

  logic [cbse_pkg::DATA_W-1:0] store [cbse_pkg::MEM_DEPTH];
  logic [cbse_pkg::DATA_W-1:0] rdata_reg;

  // ----------------------------------------------------------------
  // Storage and read register
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in) begin
    if (port.we) begin
      store[port.addr] <= port.wdata;
    end
  end

  always_ff @(posedge clk_in) begin
    rdata_reg <= store[port.addr];
  end

  assign port.rdata = rdata_reg;

endmodule : cbse_mem

`default_nettype wire

// ==== hw/cbse_shift.sv ====
// One-bit shift and rotate unit with its flag update.
`default_nettype none

module cbse_shift (
  input  wire logic                  [2:0] op_in,
  input  wire logic                  [7:0] value_in,
  input  wire logic                  [7:0] sreg_in,
  output logic                       [7:0] result_out,
  output logic                       [7:0] sreg_out
);

  logic carry;
  logic neg;

  always_comb begin
    result_out = value_in;
    carry      = sreg_in[cbse_pkg::FLG_C];
    case (op_in)
      cbse_pkg::OP_SHIFT_LEFT_LOGICAL: begin
        result_out = {value_in[6:0], 1'b0};
        carry      = value_in[7];
      end
      cbse_pkg::OP_SHIFT_RIGHT_LOGICAL: begin
        result_out = {1'b0, value_in[7:1]};
        carry      = value_in[0];
      end
      cbse_pkg::OP_ROTATE_LEFT_CARRY: begin
        result_out = {value_in[6:0], sreg_in[cbse_pkg::FLG_C]};
        carry      = value_in[7];
      end
      cbse_pkg::OP_ROTATE_RIGHT_CARRY: begin
        result_out = {sreg_in[cbse_pkg::FLG_C], value_in[7:1]};
        carry      = value_in[0];
      end
      default: begin
        result_out = value_in;
      end
    endcase
    neg                         = result_out[7];
    sreg_out                    = sreg_in;
    sreg_out[cbse_pkg::FLG_Z]   = (result_out == 8'h00);
    sreg_out[cbse_pkg::FLG_C]   = carry;
    sreg_out[cbse_pkg::FLG_N]   = neg;
    sreg_out[cbse_pkg::FLG_V]   = neg ^ carry;
  end

endmodule : cbse_shift

`default_nettype wire

// ==== hw/cbse_exec.sv ====
// Executor for flag branches, I/O bit set and clear, and one-bit shifts.
`default_nettype none

// Operation
// - Branch on negative jumps to pc plus offset plus one when the negative flag is one.
// - Branch on positive jumps to pc plus offset plus one when the negative flag is zero.
// - Signed greater-or-equal branch is taken when negative xor overflow is zero.
// - Signed less-than branch is taken when negative xor overflow is one.
// - Half-carry branches are taken on half-carry one or zero respectively.
// - Transfer-bit branches are taken on transfer flag one or zero respectively.
// - Overflow branches are taken on overflow flag one or zero respectively.
// - Interrupt-state branches are taken on global interrupt flag one or zero.
// - I/O bit set forces one bit of an I/O register to one in two cycles, flags unchanged.
// - I/O bit clear forces one bit of an I/O register to zero in two cycles, flags unchanged.
// - Logical left shift inserts zero at bit zero and updates zero, carry, negative, overflow.
// - Logical right shift inserts zero at bit seven and updates the same four flags.
// - Rotate left moves old carry into bit zero and old bit seven into carry.
// - Rotate right moves old carry into bit seven and old bit zero into carry.
module cbse_exec (
  input  wire logic        clk_in,
  input  wire logic        nrst_in,
  input  wire logic        wb_cyc_in,
  input  wire logic        wb_stb_in,
  input  wire logic        wb_we_in,
  input  wire logic [8:0]  wb_adr_in,
  input  wire logic [31:0] wb_dat_in,
  input  wire logic [3:0]  wb_sel_in,
  output logic      [31:0] wb_dat_out,
  output logic             wb_ack_out,
  output logic      [15:0] pc_out,
  output logic      [7:0]  sreg_out,
  output logic             busy_out
);

  // ----------------------------------------------------------------
  // Declarations
  // ----------------------------------------------------------------
  logic [1:0]              rst_sync_reg;
  logic                    rst_n;
  cbse_pkg::cbse_state_type state_reg;
  cbse_pkg::cbse_state_type state_next;
  cbse_pkg::cbse_op_type   op;
  logic [15:0]             instr_reg;
  logic [15:0]             pc_reg;
  logic [7:0]              sreg_reg;
  logic [1:0]              last_cyc_reg;
  logic                    bad_reg;
  logic                    ack_reg;
  logic [31:0]             dat_reg;
  logic [31:0]             dat_next;
  logic                    pend_reg;
  logic                    req;
  logic                    idle;
  logic [1:0]              region;
  logic                    bus_rf;
  logic                    bus_io;
  logic                    ctl_hit;
  logic                    mem_go;
  logic                    mem_done;
  logic                    bad_hit;
  logic                    ctl_wr;
  logic                    flag_bit;
  logic                    taken;
  logic [15:0]             target;
  logic [15:0]             pc_inc;
  logic [7:0]              bit_mask;
  logic [7:0]              shift_res;
  logic [7:0]              shift_sreg;
  logic [15:0]             instr_wr;
  logic [15:0]             pc_wr;

  cbse_mem_if rf_bus ();
  cbse_mem_if io_bus ();

  // ----------------------------------------------------------------
  // Reset release
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge nrst_in) begin
    if (!nrst_in) begin
      rst_sync_reg <= 2'h0;
    end else begin
      rst_sync_reg <= {rst_sync_reg[0], 1'b1};
    end
  end

  assign rst_n = rst_sync_reg[1];

  // ----------------------------------------------------------------
  // Instruction decode
  // ----------------------------------------------------------------
  function automatic cbse_pkg::cbse_op_type decode(input logic [15:0] ins);
    cbse_pkg::cbse_op_type kind;
    logic                  same;
    logic [2:0]            sel;
    same = ({ins[9], ins[3:0]} == ins[8:4]);
    sel  = ins[2:0];
    kind = cbse_pkg::OP_BAD;
    if ((ins & cbse_pkg::MASK_BRANCH) == cbse_pkg::OPC_BRANCH) begin
      if ((sel != cbse_pkg::FLG_C) && (sel != cbse_pkg::FLG_Z)) begin
        kind = cbse_pkg::OP_BRANCH;
      end
    end else if ((ins & cbse_pkg::MASK_IO) == cbse_pkg::OPC_IO_SET) begin
      kind = cbse_pkg::OP_IO_BIT_SET;
    end else if ((ins & cbse_pkg::MASK_IO) == cbse_pkg::OPC_IO_CLR) begin
      kind = cbse_pkg::OP_IO_BIT_CLEAR;
    end else if (((ins & cbse_pkg::MASK_TWO) == cbse_pkg::OPC_SHL) && same) begin
      kind = cbse_pkg::OP_SHIFT_LEFT_LOGICAL;
    end else if (((ins & cbse_pkg::MASK_TWO) == cbse_pkg::OPC_ROL) && same) begin
      kind = cbse_pkg::OP_ROTATE_LEFT_CARRY;
    end else if ((ins & cbse_pkg::MASK_ONE) == cbse_pkg::OPC_SHR) begin
      kind = cbse_pkg::OP_SHIFT_RIGHT_LOGICAL;
    end else if ((ins & cbse_pkg::MASK_ONE) == cbse_pkg::OPC_ROR) begin
      kind = cbse_pkg::OP_ROTATE_RIGHT_CARRY;
    end
    return kind;
  endfunction : decode

  assign op = decode(instr_reg);

  // ----------------------------------------------------------------
  // Branch condition and target
  // ----------------------------------------------------------------
  always_comb begin
    flag_bit = sreg_reg[instr_reg[2:0]];
    if (instr_reg[2:0] == cbse_pkg::FLG_S) begin
      flag_bit = sreg_reg[cbse_pkg::FLG_N] ^ sreg_reg[cbse_pkg::FLG_V];
    end
  end

  // The polarity bit selects the taken-on-one or taken-on-zero form.
  assign taken  = flag_bit ^ instr_reg[cbse_pkg::BR_POL_BIT];
  assign pc_inc = pc_reg + 16'h0001;
  assign target = pc_inc + {{9{instr_reg[cbse_pkg::BR_OFS_MSB]}},
                            instr_reg[cbse_pkg::BR_OFS_MSB:cbse_pkg::BR_OFS_LSB]};
  assign bit_mask = 8'h01 << instr_reg[cbse_pkg::BIT_MSB:0];

  // ----------------------------------------------------------------
  // Shift unit
  // ----------------------------------------------------------------
  cbse_shift shift_unit (
    .op_in      (op),
    .value_in   (rf_bus.rdata),
    .sreg_in    (sreg_reg),
    .result_out (shift_res),
    .sreg_out   (shift_sreg)
  );

  // ----------------------------------------------------------------
  // Bus decode
  // ----------------------------------------------------------------
  assign req      = wb_cyc_in & wb_stb_in & ~ack_reg;
  assign idle     = (state_reg == cbse_pkg::ST_IDLE);
  assign region   = wb_adr_in[8:cbse_pkg::REGION_LSB];
  assign bus_rf   = req & idle & (region == cbse_pkg::REGION_RF);
  assign bus_io   = req & idle & (region == cbse_pkg::REGION_IO);
  assign ctl_hit  = req & idle & (region == cbse_pkg::REGION_CTL);
  assign bad_hit  = req & idle & (region == 2'h3);
  assign mem_go   = (bus_rf | bus_io) & ~pend_reg;
  assign mem_done = (bus_rf | bus_io) & pend_reg;
  assign ctl_wr   = ctl_hit & wb_we_in;

  // Byte lanes merge so that a partial write keeps the untouched byte.
  assign instr_wr = {wb_sel_in[1] ? wb_dat_in[15:8] : instr_reg[15:8],
                     wb_sel_in[0] ? wb_dat_in[7:0]  : instr_reg[7:0]};
  assign pc_wr    = {wb_sel_in[1] ? wb_dat_in[15:8] : pc_reg[15:8],
                     wb_sel_in[0] ? wb_dat_in[7:0]  : pc_reg[7:0]};

  // ----------------------------------------------------------------
  // Memory ports
  // ----------------------------------------------------------------
  always_comb begin
    rf_bus.we    = (mem_go & bus_rf & wb_we_in & wb_sel_in[0]);
    rf_bus.wdata = wb_dat_in[7:0];
    if (bus_rf) begin
      rf_bus.addr = wb_adr_in[6:cbse_pkg::INDEX_LSB];
    end else if (idle) begin
      rf_bus.addr = instr_wr[cbse_pkg::RD_MSB:cbse_pkg::RD_LSB];
    end else begin
      rf_bus.addr = instr_reg[cbse_pkg::RD_MSB:cbse_pkg::RD_LSB];
    end
    if ((state_reg == cbse_pkg::ST_EXEC) && op[2]) begin
      rf_bus.we    = 1'b1;
      rf_bus.wdata = shift_res;
    end
  end

  always_comb begin
    io_bus.we    = (mem_go & bus_io & wb_we_in & wb_sel_in[0]);
    io_bus.wdata = wb_dat_in[7:0];
    if (bus_io) begin
      io_bus.addr = wb_adr_in[6:cbse_pkg::INDEX_LSB];
    end else if (idle) begin
      io_bus.addr = instr_wr[cbse_pkg::IOA_MSB:cbse_pkg::IOA_LSB];
    end else begin
      io_bus.addr = instr_reg[cbse_pkg::IOA_MSB:cbse_pkg::IOA_LSB];
    end
    if (state_reg == cbse_pkg::ST_SECOND) begin
      if (op == cbse_pkg::OP_IO_BIT_SET) begin
        io_bus.we    = 1'b1;
        io_bus.wdata = io_bus.rdata | bit_mask;
      end else if (op == cbse_pkg::OP_IO_BIT_CLEAR) begin
        io_bus.we    = 1'b1;
        io_bus.wdata = io_bus.rdata & ~bit_mask;
      end
    end
  end

  cbse_mem reg_file (
    .clk_in (clk_in),
    .port   (rf_bus.mem)
  );

  cbse_mem io_space (
    .clk_in (clk_in),
    .port   (io_bus.mem)
  );

  // ----------------------------------------------------------------
  // Sequencer
  // ----------------------------------------------------------------
  always_comb begin
    state_next = state_reg;
    case (state_reg)
      cbse_pkg::ST_IDLE: begin
        if (ctl_wr && (wb_adr_in == cbse_pkg::ADR_INSTR)) begin
          state_next = cbse_pkg::ST_EXEC;
        end
      end
      cbse_pkg::ST_EXEC: begin
        state_next = cbse_pkg::ST_IDLE;
        if ((op == cbse_pkg::OP_BRANCH) && taken) begin
          state_next = cbse_pkg::ST_SECOND;
        end
        if ((op == cbse_pkg::OP_IO_BIT_SET) || (op == cbse_pkg::OP_IO_BIT_CLEAR)) begin
          state_next = cbse_pkg::ST_SECOND;
        end
      end
      cbse_pkg::ST_SECOND: begin
        state_next = cbse_pkg::ST_IDLE;
      end
      default: begin
        state_next = cbse_pkg::ST_IDLE;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      state_reg <= cbse_pkg::ST_IDLE;
    end else begin
      state_reg <= state_next;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      instr_reg <= cbse_pkg::INSTR_RST;
    end else if (ctl_wr && (wb_adr_in == cbse_pkg::ADR_INSTR)) begin
      instr_reg <= instr_wr;
    end
  end

  // ----------------------------------------------------------------
  // Program counter
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pc_reg <= cbse_pkg::PC_RST;
    end else if (ctl_wr && (wb_adr_in == cbse_pkg::ADR_PC)) begin
      pc_reg <= pc_wr;
    end else if (state_reg == cbse_pkg::ST_EXEC) begin
      if (state_next == cbse_pkg::ST_IDLE) begin
        pc_reg <= pc_inc;
      end
    end else if (state_reg == cbse_pkg::ST_SECOND) begin
      if (op == cbse_pkg::OP_BRANCH) begin
        pc_reg <= target;
      end else begin
        pc_reg <= pc_inc;
      end
    end
  end

  // ----------------------------------------------------------------
  // Status flags
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      sreg_reg <= cbse_pkg::SREG_RST;
    end else if (ctl_wr && (wb_adr_in == cbse_pkg::ADR_SREG) && wb_sel_in[0]) begin
      sreg_reg <= wb_dat_in[7:0];
    end else if ((state_reg == cbse_pkg::ST_EXEC) && op[2]) begin
      sreg_reg <= shift_sreg;
    end
  end

  // ----------------------------------------------------------------
  // Execution status
  // ----------------------------------------------------------------
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      last_cyc_reg <= cbse_pkg::CYC_RST;
    end else if ((state_reg == cbse_pkg::ST_EXEC) && (state_next == cbse_pkg::ST_IDLE)) begin
      last_cyc_reg <= cbse_pkg::CYC_ONE;
    end else if (state_reg == cbse_pkg::ST_SECOND) begin
      last_cyc_reg <= cbse_pkg::CYC_TWO;
    end
  end

  // An undecodable word sets the sticky flag; the set wins over a clear.
  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      bad_reg <= 1'b0;
    end else if ((state_reg == cbse_pkg::ST_EXEC) && (op == cbse_pkg::OP_BAD)) begin
      bad_reg <= 1'b1;
    end else if (ctl_wr && (wb_adr_in == cbse_pkg::ADR_STAT) && wb_sel_in[0]
                 && wb_dat_in[cbse_pkg::STAT_BAD]) begin
      bad_reg <= 1'b0;
    end
  end

  // ----------------------------------------------------------------
  // Bus answer
  // ----------------------------------------------------------------
  always_comb begin
    dat_next = 32'h00000000;
    if (mem_done) begin
      dat_next[7:0] = bus_rf ? rf_bus.rdata : io_bus.rdata;
    end else if (ctl_hit) begin
      case (wb_adr_in)
        cbse_pkg::ADR_INSTR: begin
          dat_next[15:0] = instr_reg;
        end
        cbse_pkg::ADR_PC: begin
          dat_next[15:0] = pc_reg;
        end
        cbse_pkg::ADR_SREG: begin
          dat_next[7:0] = sreg_reg;
        end
        cbse_pkg::ADR_STAT: begin
          dat_next[cbse_pkg::STAT_BUSY] = ~idle;
          dat_next[cbse_pkg::STAT_BAD]  = bad_reg;
          dat_next[cbse_pkg::STAT_CYC_LSB +: cbse_pkg::CYC_W] = last_cyc_reg;
        end
        default: begin
          dat_next = 32'h00000000;
        end
      endcase
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      pend_reg <= 1'b0;
    end else begin
      pend_reg <= mem_go;
    end
  end

  always_ff @(posedge clk_in or negedge rst_n) begin
    if (!rst_n) begin
      ack_reg <= 1'b0;
      dat_reg <= 32'h00000000;
    end else begin
      ack_reg <= ctl_hit | mem_done | bad_hit;
      if (ctl_hit | mem_done | bad_hit) begin
        dat_reg <= dat_next;
      end
    end
  end

  // ----------------------------------------------------------------
  // Outputs
  // ----------------------------------------------------------------
  assign wb_ack_out = ack_reg;
  assign wb_dat_out = dat_reg;
  assign pc_out     = pc_reg;
  assign sreg_out   = sreg_reg;
  assign busy_out   = ~idle;

endmodule : cbse_exec

`default_nettype wire

// ==== verification/cbse_wb_master.sv ====
// Wishbone classic master model, one transfer per go pulse.
`default_nettype none
module cbse_wb_master (
  input  wire logic        clk_in,
  input  wire logic        go_in,
  input  wire logic [41:0] req_in,
  input  wire logic        ack_in,
  input  wire logic [31:0] rd_in,
  output logic             cyc_out,
  output logic      [41:0] bus_out,
  output logic      [31:0] rd_out,
  output logic             done_out
);
  timeunit 1ns;
  timeprecision 100ps;
  initial begin
    cyc_out = 1'b0;
    bus_out = '0;
    rd_out = '0;
    done_out = 1'b0;
  end
  always @(posedge clk_in) begin
    done_out <= 1'b0;
    if (cyc_out && ack_in) begin
      cyc_out <= 1'b0;
      bus_out <= ~bus_out;
      rd_out <= rd_in;
      done_out <= 1'b1;
    end else if (go_in && !cyc_out) begin
      cyc_out <= 1'b1;
      bus_out <= req_in;
    end
  end
endmodule : cbse_wb_master
`default_nettype wire

// ==== verification/cbse_exec_asserts.sv ====
// Port-level checks on the executor.
`default_nettype none
module cbse_exec_asserts (
  input wire logic        clk_in,
  input wire logic        nrst_in,
  input wire logic        wb_cyc_in,
  input wire logic        wb_stb_in,
  input wire logic        wb_we_in,
  input wire logic [8:0]  wb_adr_in,
  input wire logic [31:0] wb_dat_in,
  input wire logic        wb_ack_out,
  input wire logic [15:0] pc_out,
  input wire logic [7:0]  sreg_out,
  input wire logic        busy_out
);
  logic go, br, io, sh;
  logic [15:0] op;
  assign op = wb_dat_in[15:0];
  assign go = wb_ack_out && wb_we_in && wb_adr_in == cbse_pkg::ADR_INSTR;
  assign br = go && (op & cbse_pkg::MASK_BRANCH) == cbse_pkg::OPC_BRANCH;
  assign io = go && (op & 16'hfd00) == cbse_pkg::OPC_IO_CLR;
  assign sh = go && ((op & 16'hec00) == cbse_pkg::OPC_SHL || (op & 16'hfe0e) == cbse_pkg::OPC_SHR);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!nrst_in);
  ack_pulse_a: assert property (wb_ack_out |=> !wb_ack_out)
    else $error("ack held");
  ack_cause_a: assert property (wb_ack_out |-> $past(wb_cyc_in && wb_stb_in))
    else $error("ack without request");
  busy_ack_a: assert property (busy_out && $past(busy_out) |-> !wb_ack_out)
    else $error("ack while busy");
  busy_len_a: assert property ($rose(busy_out) |-> ##[1:2] !busy_out)
    else $error("busy too long");
  br_flags_a: assert property (br |=> $stable(sreg_out) [*3])
    else $error("branch changed flags");
  io_len_a: assert property (io |-> busy_out ##1 busy_out ##1 !busy_out)
    else $error("bit op length");
  sh_len_a: assert property (sh |-> busy_out ##1 !busy_out)
    else $error("shift length");
  sh_keep_a: assert property (sh |=> ##1 sreg_out[7:4] == $past(sreg_out[7:4], 2))
    else $error("shift touched upper flags");
  idle_a: assert property (!busy_out && !wb_cyc_in |=> $stable(pc_out) && $stable(sreg_out))
    else $error("state moved while idle");
endmodule : cbse_exec_asserts
`default_nettype wire

// ==== verification/cbse_exec_tb.sv ====
// Self-checking bench for the executor.
`default_nettype none
module cbse_exec_tb;
  timeunit 1ns;
  timeprecision 100ps;
  logic clk_in, nrst_in, go, cyc, ack, done, busy;
  logic [41:0] req, bus;
  logic [31:0] rdo, rd;
  logic [15:0] pc;
  logic [7:0] sreg;
  int n_fail, check_count;
  cbse_exec u_cbse_exec (.clk_in(clk_in), .nrst_in(nrst_in), .wb_cyc_in(cyc), .wb_stb_in(cyc),
    .wb_we_in(bus[41]), .wb_adr_in(bus[40:32]), .wb_dat_in(bus[31:0]), .wb_sel_in(4'h3),
    .wb_dat_out(rdo), .wb_ack_out(ack), .pc_out(pc), .sreg_out(sreg), .busy_out(busy));
  cbse_wb_master u_cbse_wb_master (.clk_in(clk_in), .go_in(go), .req_in(req), .ack_in(ack),
    .rd_in(rdo), .cyc_out(cyc), .bus_out(bus), .rd_out(rd), .done_out(done));
  initial begin
    clk_in = 1'b0;
    forever #12.5 clk_in = ~clk_in;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    check_count++;
    if (seen !== exp) begin
      n_fail++;
      $display("[ERR] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask : check
  task automatic xfer(input logic w, input logic [8:0] a, input logic [31:0] d);
    int i;
    @(posedge clk_in);
    go <= 1'b1;
    req <= {w, a, d};
    @(posedge clk_in);
    go <= 1'b0;
    for (i = 0; i < 40 && done !== 1'b1; i++) @(negedge clk_in);
    check({31'h0, done}, 32'h1);
  endtask : xfer
  task automatic run(input logic [7:0] s, input logic [15:0] p, input logic [15:0] ins,
                     input logic [15:0] pe, input logic [7:0] se, input logic [1:0] ce);
    xfer(1'b1, cbse_pkg::ADR_SREG, {24'h0, s});
    xfer(1'b1, cbse_pkg::ADR_PC, {16'h0, p});
    xfer(1'b1, cbse_pkg::ADR_INSTR, {16'h0, ins});
    xfer(1'b0, cbse_pkg::ADR_STAT, 32'h0);
    check(rd, {26'h0, ce, 4'h0});
    check({8'h0, se, pc}, {8'h0, se, pe});
    check({24'h0, sreg}, {24'h0, se});
  endtask : run
  task automatic t_branch;
    logic [7:0] pat [4] = '{8'h10, 8'hf4, 8'h0c, 8'h08};
    logic c;
    for (int s = 2; s < 8; s++)
      for (int p = 0; p < 2; p++)
        for (int f = 0; f < 4; f++) begin
          c = (s == 4 ? pat[f][2] ^ pat[f][3] : pat[f][s]) ^ p[0];
          run(pat[f], 16'h0001, {5'h1e, p[0], 7'h7d, s[2:0]}, c ? 16'hffff : 16'h0002,
              pat[f], c ? 2'h2 : 2'h1);
        end
  endtask : t_branch
  task automatic t_io;
    xfer(1'b1, 9'h10c, 32'h00);
    run(8'h5a, 16'h0100, 16'h9a1e, 16'h0101, 8'h5a, 2'h2);
    xfer(1'b0, 9'h10c, 32'h0);
    check({24'h0, rd[7:0]}, 32'h40);
    xfer(1'b1, 9'h10c, 32'hff);
    run(8'ha5, 16'h0200, 16'h981e, 16'h0201, 8'ha5, 2'h2);
    xfer(1'b0, 9'h10c, 32'h0);
    check({24'h0, rd[7:0]}, 32'hbf);
  endtask : t_io
  task automatic t_shift;
    logic [15:0] ins [4] = '{16'h0c55, 16'h9456, 16'h1c55, 16'h9457};
    logic [7:0] v, s, r;
    logic cn;
    for (int o = 0; o < 4; o++)
      for (int k = 0; k < 2; k++) begin
        v = k ? 8'h01 : 8'h80;
        s = k ? 8'hf1 : 8'h10;
        cn = o[0] ? v[0] : v[7];
        r = o[0] ? {o[1] & s[0], v[7:1]} : {v[6:0], o[1] & s[0]};
        xfer(1'b1, 9'h094, {24'h0, v});
        run(s, 16'h0010, ins[o], 16'h0011, {s[7:4], r[7] ^ cn, r[7], r == 8'h0, cn}, 2'h1);
        xfer(1'b0, 9'h094, 32'h0);
        check({24'h0, rd[7:0]}, {24'h0, r});
      end
  endtask : t_shift
  task automatic t_bad;
    xfer(1'b1, cbse_pkg::ADR_INSTR, 32'hf000);
    xfer(1'b0, cbse_pkg::ADR_STAT, 32'h0);
    check(rd, 32'h12);
    xfer(1'b1, cbse_pkg::ADR_STAT, 32'h2);
    xfer(1'b0, cbse_pkg::ADR_STAT, 32'h0);
    check(rd, 32'h10);
  endtask : t_bad
  task automatic summarize;
    $display("checks %0d mismatches %0d", check_count, n_fail);
    if (n_fail == 0 && check_count > 0) $display("Finished cleanly");
    else $display("Finished with errors");
    $finish;
  endtask : summarize
  initial begin
    nrst_in = 1'b0;
    go = 1'b0;
    req = '0;
    repeat (2) @(posedge clk_in);
    nrst_in <= 1'b1;
    repeat (3) @(posedge clk_in);
    check({8'h0, sreg, pc}, 32'h0);
    xfer(1'b1, 9'h180, 32'hff);
    xfer(1'b0, 9'h180, 32'h0);
    check(rd, 32'h0);
    t_branch();
    t_io();
    t_shift();
    t_bad();
    summarize();
  end
  initial begin
    #500000;
    n_fail++;
    summarize();
  end
endmodule : cbse_exec_tb
bind cbse_exec cbse_exec_asserts u_cbse_exec_asserts (.*);
`default_nettype wire
